/* File: design/tcm_bank.sv */
`timescale 1ns/1ps
module tcm_bank
	import tcm_pkg::*;
#(
	parameter bit IS_ROM = 1'b0
) (
	input  wire logic                    core_clk,
	input  wire logic                    srst,
	input  wire logic                    we,
	input  wire logic                    init_we,
	input  wire logic [tcm_pkg::IDX_W-1:0]  idx,
	input  wire logic [tcm_pkg::DATA_W-1:0] wdata,
	output logic      [tcm_pkg::DATA_W-1:0] rdata
);
	import tcm_pkg::*;

	logic [DATA_W-1:0] mem_q [MEM_WORDS];

	// ROM contents come only through the preload path; core stores are dropped.
	generate
		for (genvar i = 0; i < MEM_WORDS; i++) begin : g_word
			always_ff @(posedge core_clk) begin
				if (srst) begin
					mem_q[i] <= '0;
				end else if ((IS_ROM ? init_we : (we | init_we)) && idx == IDX_W'(i)) begin
					mem_q[i] <= wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata <= '0;
		end else begin
			rdata <= mem_q[idx];
		end
	end

endmodule : tcm_bank

/* File: design/tcm_pkg.sv */
package tcm_pkg;

	localparam int unsigned ADDR_W        = 32;
	localparam int unsigned DATA_W        = 32;
	localparam int unsigned WORD_BYTES    = 4;
	localparam int unsigned MEM_WORDS     = 256;
	localparam int unsigned IDX_W         = 8;
	localparam int unsigned A_MAX_BYTES   = 8388608;
	localparam int unsigned OOO_MAX_BYTES = 131072;
	localparam logic [31:0] A_BASE_RST    = 32'h0000_0000;
	localparam logic [31:0] B_BASE_RST    = 32'h0080_0000;
	localparam int unsigned WAIT_W        = 3;
	localparam logic [2:0]  WAIT_RST      = 3'h0;
	localparam int unsigned SYNC_STAGES   = 3;

	typedef enum logic [1:0] {
		MEM_NORMAL = 2'h0,
		MEM_DEVICE = 2'h1,
		MEM_STRONG = 2'h2
	} mem_type_e;

	typedef enum logic [1:0] {
		SRC_DATA  = 2'h0,
		SRC_FETCH = 2'h1,
		SRC_SLAVE = 2'h2,
		SRC_NONE  = 2'h3
	} src_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_DONE = 2'h3
	} acc_state_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} req_s;

	typedef struct packed {
		logic        valid;
		logic        fault;
		logic [31:0] rdata;
	} rsp_s;

	typedef struct packed {
		mem_type_e mtype;
		logic      xn;
	} attr_s;

endpackage : tcm_pkg

/* File: design/tightly_coupled_memory_port.sv */
`timescale 1ns/1ps
module tightly_coupled_memory_port
	import tcm_pkg::*;
#(
	parameter bit          OOO_VARIANT = 1'b0,
	parameter bit          A_IS_ROM    = 1'b0,
	parameter bit          B_IS_ROM    = 1'b0,
	parameter int unsigned A_BYTES     = MEM_WORDS * WORD_BYTES,
	parameter int unsigned B_BYTES     = MEM_WORDS * WORD_BYTES
) (
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                fetch_hold_n,
	input  wire logic                a_en_strap,
	input  wire logic                b_en_strap,
	input  wire logic [2:0]          a_wait_cfg,
	input  wire logic                i_wait_cfg,
	input  wire tcm_pkg::req_s       data_req,
	input  wire tcm_pkg::attr_s      data_attr,
	input  wire tcm_pkg::req_s       fetch_req,
	input  wire tcm_pkg::attr_s      fetch_attr,
	input  wire tcm_pkg::req_s       slv_req,
	output tcm_pkg::rsp_s            data_rsp,
	output tcm_pkg::rsp_s            fetch_rsp,
	output tcm_pkg::rsp_s            slv_rsp,
	output logic                     ext_data_req,
	output logic                     ext_fetch_req,
	output logic                     fetch_allowed,
	output logic                     a_enabled,
	output logic                     b_enabled
);
	import tcm_pkg::*;

	// Size limits are checked at elaboration so an oversized build never exists.
	if (!OOO_VARIANT && (A_BYTES > A_MAX_BYTES || B_BYTES > A_MAX_BYTES)) begin : g_size_io
		$error("memory larger than in-order limit");
	end
	if (OOO_VARIANT && (A_BYTES > OOO_MAX_BYTES || B_BYTES > OOO_MAX_BYTES)) begin : g_size_ooo
		$error("memory larger than out-of-order limit");
	end
	if (OOO_VARIANT && (A_IS_ROM || B_IS_ROM)) begin : g_rom_ooo
		$error("out-of-order memories must be SRAM");
	end

	// Pin inputs pass three flops; a change counts when stages two and three agree.
	logic [SYNC_STAGES-1:0] hold_sync_q;
	logic [SYNC_STAGES-1:0] a_sync_q;
	logic [SYNC_STAGES-1:0] b_sync_q;
	logic                   hold_n_q;
	logic                   a_pin_q;
	logic                   b_pin_q;

	always_ff @(posedge core_clk) begin
		hold_sync_q <= {hold_sync_q[SYNC_STAGES-2:0], fetch_hold_n};
		a_sync_q    <= {a_sync_q[SYNC_STAGES-2:0], a_en_strap};
		b_sync_q    <= {b_sync_q[SYNC_STAGES-2:0], b_en_strap};
	end

	always_ff @(posedge core_clk) begin
		if (hold_sync_q[1] == hold_sync_q[2]) begin
			hold_n_q <= hold_sync_q[2];
		end
		if (a_sync_q[1] == a_sync_q[2]) begin
			a_pin_q <= a_sync_q[2];
		end
		if (b_sync_q[1] == b_sync_q[2]) begin
			b_pin_q <= b_sync_q[2];
		end
	end

	// Straps are caught during reset; in the out-of-order build only the
	// instruction memory (bank A) is strap controlled, the data memory is always on.
	logic held_q;
	logic [31:0] a_base_q;
	logic [31:0] b_base_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			a_enabled <= a_pin_q;
			b_enabled <= OOO_VARIANT ? 1'b1 : b_pin_q;
			a_base_q  <= A_BASE_RST;
			b_base_q  <= B_BASE_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			held_q <= ~hold_n_q;
		end else if (hold_n_q) begin
			held_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			fetch_allowed <= 1'b0;
		end else begin
			fetch_allowed <= ~held_q;
		end
	end

	// Address decode; an enabled range shadows external memory.
	function automatic logic hit(input logic [31:0] addr, input logic [31:0] base,
		input int unsigned bytes);
		hit = (addr - base) < bytes;
	endfunction : hit

	logic d_hit_a, d_hit_b, f_hit_a, f_hit_b, s_hit_a, s_hit_b;
	logic d_ok, f_ok, f_go;

	always_comb begin
		d_hit_a = a_enabled & hit(data_req.addr, a_base_q, A_BYTES) & ~OOO_VARIANT;
		d_hit_b = b_enabled & hit(data_req.addr, b_base_q, B_BYTES);
		f_hit_a = a_enabled & hit(fetch_req.addr, a_base_q, A_BYTES);
		f_hit_b = b_enabled & hit(fetch_req.addr, b_base_q, B_BYTES) & ~OOO_VARIANT;
		s_hit_a = hit(slv_req.addr, a_base_q, A_BYTES);
		s_hit_b = hit(slv_req.addr, b_base_q, B_BYTES);
		d_ok    = data_attr.mtype == MEM_NORMAL;
		f_ok    = fetch_attr.mtype == MEM_NORMAL && !fetch_attr.xn;
		f_go    = fetch_req.valid & fetch_allowed;
	end

	// Per-bank grant: data first, fetch second, slave last.
	src_e grant_a, grant_b;

	always_comb begin
		grant_a = SRC_NONE;
		grant_b = SRC_NONE;
		if (data_req.valid && d_ok && d_hit_a) grant_a = SRC_DATA;
		else if (f_go && f_ok && f_hit_a) grant_a = SRC_FETCH;
		else if (slv_req.valid && s_hit_a) grant_a = SRC_SLAVE;
		if (data_req.valid && d_ok && d_hit_b) grant_b = SRC_DATA;
		else if (f_go && f_ok && f_hit_b) grant_b = SRC_FETCH;
		else if (slv_req.valid && s_hit_b && !(s_hit_a)) grant_b = SRC_SLAVE;
	end

	function automatic req_s pick(input src_e g, input req_s d, input req_s f, input req_s s);
		case (g)
			SRC_DATA:  pick = d;
			SRC_FETCH: pick = f;
			SRC_SLAVE: pick = s;
			default:   pick = '0;
		endcase
	endfunction : pick

	req_s ra, rb;
	logic [DATA_W-1:0] rdata_a, rdata_b;

	always_comb begin
		ra = pick(grant_a, data_req, fetch_req, slv_req);
		rb = pick(grant_b, data_req, fetch_req, slv_req);
	end

	tcm_bank #(.IS_ROM(A_IS_ROM)) u_bank_a (
		.core_clk (core_clk),
		.srst     (srst),
		.we       (ra.valid & ra.write & grant_a != SRC_SLAVE),
		.init_we  (ra.valid & ra.write & grant_a == SRC_SLAVE),
		.idx      (ra.addr[IDX_W+1:2]),
		.wdata    (ra.wdata),
		.rdata    (rdata_a)
	);

	tcm_bank #(.IS_ROM(B_IS_ROM)) u_bank_b (
		.core_clk (core_clk),
		.srst     (srst),
		.we       (rb.valid & rb.write & grant_b != SRC_SLAVE),
		.init_we  (rb.valid & rb.write & grant_b == SRC_SLAVE),
		.idx      (rb.addr[IDX_W+1:2]),
		.wdata    (rb.wdata),
		.rdata    (rdata_b)
	);

	// Wait counts: in-order uses the configured count, out-of-order fetch
	// memory adds at most one cycle and data memory always none.
	logic [WAIT_W-1:0] wait_a, wait_b;
	always_comb begin
		wait_a = OOO_VARIANT ? {2'h0, i_wait_cfg} : a_wait_cfg;
		wait_b = OOO_VARIANT ? WAIT_RST : a_wait_cfg;
	end

	// One response pipeline per bank, trading latency for timing closure.
	acc_state_e st_q [2];
	logic [WAIT_W-1:0] cnt_q [2];
	src_e src_q [2];

	generate
		for (genvar b = 0; b < 2; b++) begin : g_pipe
			src_e g;
			logic [WAIT_W-1:0] w;
			assign g = (b == 0) ? grant_a : grant_b;
			assign w = (b == 0) ? wait_a : wait_b;
			always_ff @(posedge core_clk) begin
				if (srst) begin
					st_q[b]  <= ST_IDLE;
					cnt_q[b] <= WAIT_RST;
					src_q[b] <= SRC_NONE;
				end else begin
					case (st_q[b])
						ST_IDLE: begin
							src_q[b] <= g;
							cnt_q[b] <= w;
							if (g != SRC_NONE) st_q[b] <= (w == WAIT_RST) ? ST_DONE : ST_WAIT;
						end
						ST_WAIT: begin
							cnt_q[b] <= cnt_q[b] - 3'h1;
							if (cnt_q[b] == 3'h1) st_q[b] <= ST_DONE;
						end
						ST_DONE: st_q[b] <= ST_IDLE;
						default: st_q[b] <= ST_IDLE;
					endcase
				end
			end
		end
	endgenerate

	// Responses, faults and external routing.
	function automatic rsp_s mk(input src_e want, input logic [DATA_W-1:0] ra_d,
		input logic [DATA_W-1:0] rb_d, input acc_state_e sa, input acc_state_e sb,
		input src_e qa, input src_e qb);
		mk = '0;
		if (sa == ST_DONE && qa == want) begin
			mk.valid = 1'b1;
			mk.rdata = ra_d;
		end else if (sb == ST_DONE && qb == want) begin
			mk.valid = 1'b1;
			mk.rdata = rb_d;
		end
	endfunction : mk

	always_ff @(posedge core_clk) begin
		if (srst) begin
			data_rsp  <= '0;
			fetch_rsp <= '0;
			slv_rsp   <= '0;
		end else begin
			data_rsp  <= mk(SRC_DATA, rdata_a, rdata_b, st_q[0], st_q[1], src_q[0], src_q[1]);
			fetch_rsp <= mk(SRC_FETCH, rdata_a, rdata_b, st_q[0], st_q[1], src_q[0], src_q[1]);
			slv_rsp   <= mk(SRC_SLAVE, rdata_a, rdata_b, st_q[0], st_q[1], src_q[0], src_q[1]);
			if (data_req.valid && (d_hit_a || d_hit_b) && !d_ok) begin
				data_rsp.valid <= 1'b1;
				data_rsp.fault <= 1'b1;
			end
			if (f_go && (f_hit_a || f_hit_b) && !f_ok) begin
				fetch_rsp.valid <= 1'b1;
				fetch_rsp.fault <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ext_data_req  <= 1'b0;
			ext_fetch_req <= 1'b0;
		end else begin
			ext_data_req  <= data_req.valid & ~d_hit_a & ~d_hit_b;
			ext_fetch_req <= f_go & ~f_hit_a & ~f_hit_b;
		end
	end

endmodule : tightly_coupled_memory_port

/* File: sim/boot_master.sv */
`timescale 1ns/1ps
module boot_master
	import tcm_pkg::*;
(
	input  wire logic          core_clk,
	input  wire tcm_pkg::rsp_s slv_rsp,
	output tcm_pkg::req_s      slv_req,
	output logic               fetch_hold_n
);
	initial begin
		slv_req = '0;
		fetch_hold_n = 1'b0;
	end
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		@(posedge core_clk);
		slv_req <= '{1'b1, w, a, d};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!slv_rsp.valid && n < 20);
		rd = slv_rsp.rdata;
		// Released lines show the inverse so stale values cannot pass.
		slv_req <= '{1'b0, 1'b0, ~a, ~d};
		// The bank may retake the request at the release edge; let that answer drain.
		repeat (2) @(posedge core_clk);
	endtask : xfer
	task automatic release_hold();
		@(posedge core_clk);
		fetch_hold_n <= 1'b1;
	endtask : release_hold
endmodule : boot_master

/* File: sim/tcm_port_chk.sv */
`timescale 1ns/1ps
module tcm_port_chk
	import tcm_pkg::*;
(
	input wire logic          core_clk,
	input wire logic          srst,
	input wire logic          fetch_hold_n,
	input wire logic          a_en_strap,
	input wire logic          b_en_strap,
	input wire logic [2:0]    a_wait_cfg,
	input wire tcm_pkg::req_s data_req,
	input wire tcm_pkg::attr_s data_attr,
	input wire tcm_pkg::req_s fetch_req,
	input wire tcm_pkg::attr_s fetch_attr,
	input wire tcm_pkg::rsp_s data_rsp,
	input wire tcm_pkg::rsp_s fetch_rsp,
	input wire tcm_pkg::rsp_s slv_rsp,
	input wire logic          ext_data_req,
	input wire logic          fetch_allowed,
	input wire logic          a_enabled,
	input wire logic          b_enabled
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	logic d_a;
	logic f_a;
	// Bank A covers the first 1 KB in the default build.
	assign d_a = data_req.addr[31:10] == 22'h0 && data_attr.mtype == MEM_NORMAL;
	assign f_a = fetch_req.addr[31:10] == 22'h0 && fetch_attr.mtype == MEM_NORMAL;
	enables_a: assert property ($fell(srst) |-> a_enabled == a_en_strap && b_enabled == b_en_strap)
		else $error("enables differ from straps");
	fetch_gate_a: assert property (fetch_rsp.valid |-> $past(fetch_allowed))
		else $error("fetch answered while held");
	hold_a: assert property ($rose(fetch_allowed) |-> $past(fetch_hold_n, 2))
		else $error("fetch allowed while hold low");
	lat_zero_a: assert property ($rose(data_req.valid) && d_a && a_wait_cfg == 3'h0
		|-> !data_rsp.valid ##2 data_rsp.valid)
		else $error("zero-wait latency wrong");
	lat_wait_a: assert property ($rose(data_req.valid) && d_a && a_wait_cfg == 3'h2
		|-> !data_rsp.valid [*4] ##1 data_rsp.valid)
		else $error("wait latency wrong");
	prio_a: assert property ($rose(data_req.valid) && $rose(fetch_req.valid) && d_a && f_a
		&& a_wait_cfg == 3'h0 |-> ##2 data_rsp.valid && !fetch_rsp.valid)
		else $error("fetch beat data");
	fault_d_a: assert property ($rose(data_req.valid) && data_attr.mtype != MEM_NORMAL
		|=> data_rsp.valid && data_rsp.fault)
		else $error("data attribute fault missing");
	fault_f_a: assert property ($rose(fetch_req.valid) && fetch_allowed
		&& fetch_attr.mtype != MEM_NORMAL |=> fetch_rsp.fault)
		else $error("fetch from device range allowed");
	tcm_wins_a: assert property (data_req.valid && a_enabled && d_a |=> !ext_data_req)
		else $error("bank hit went external");
	miss_a: assert property ($rose(data_req.valid) && data_req.addr[31:24] == 8'hF0
		|=> ext_data_req)
		else $error("miss not sent external");
	cover property (data_rsp.valid && !data_rsp.fault);
	cover property (fetch_rsp.valid && fetch_rsp.fault);
	cover property (slv_rsp.valid);
endmodule : tcm_port_chk

bind tightly_coupled_memory_port tcm_port_chk chk_i (.core_clk(core_clk), .srst(srst),
	.fetch_hold_n(fetch_hold_n), .a_en_strap(a_en_strap), .b_en_strap(b_en_strap),
	.a_wait_cfg(a_wait_cfg), .data_req(data_req), .data_attr(data_attr),
	.fetch_req(fetch_req), .fetch_attr(fetch_attr), .data_rsp(data_rsp),
	.fetch_rsp(fetch_rsp), .slv_rsp(slv_rsp), .ext_data_req(ext_data_req),
	.fetch_allowed(fetch_allowed), .a_enabled(a_enabled), .b_enabled(b_enabled));

/* File: sim/tightly_coupled_memory_port_tb.sv */
`timescale 1ns/1ps
module tightly_coupled_memory_port_tb;
	import tcm_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] a_wait_cfg = 3'h0;
	req_s data_req = '0;
	req_s fetch_req = '0;
	attr_s data_attr = '{MEM_NORMAL, 1'b0};
	attr_s fetch_attr = '{MEM_NORMAL, 1'b0};
	req_s slv_req;
	logic fetch_hold_n;
	rsp_s data_rsp;
	rsp_s fetch_rsp;
	rsp_s slv_rsp;
	logic ext_data_req;
	logic ext_fetch_req;
	logic fetch_allowed;
	logic a_enabled;
	logic b_enabled;
	int failures = 0;
	int cmp_count = 0;
	always #10 core_clk = ~core_clk;
	boot_master pm (.core_clk(core_clk), .slv_rsp(slv_rsp), .slv_req(slv_req),
		.fetch_hold_n(fetch_hold_n));
	tightly_coupled_memory_port DUT (.core_clk(core_clk), .srst(srst),
		.fetch_hold_n(fetch_hold_n), .a_en_strap(1'b1), .b_en_strap(1'b1),
		.a_wait_cfg(a_wait_cfg), .i_wait_cfg(1'b0), .data_req(data_req),
		.data_attr(data_attr), .fetch_req(fetch_req), .fetch_attr(fetch_attr),
		.slv_req(slv_req), .data_rsp(data_rsp), .fetch_rsp(fetch_rsp), .slv_rsp(slv_rsp),
		.ext_data_req(ext_data_req), .ext_fetch_req(ext_fetch_req),
		.fetch_allowed(fetch_allowed), .a_enabled(a_enabled), .b_enabled(b_enabled));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	// Requests drop at the edge that samples the answer; a retake there is drained.
	task automatic acc(input bit f, input logic [31:0] a, output rsp_s r, output int n);
		@(posedge core_clk);
		if (f) fetch_req <= '{1'b1, 1'b0, a, 32'h0};
		else data_req <= '{1'b1, 1'b0, a, 32'h0};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!(f ? fetch_rsp.valid : data_rsp.valid) && n < 20);
		r = f ? fetch_rsp : data_rsp;
		fetch_req.valid <= 1'b0;
		data_req.valid <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : acc
	task automatic t_reset();
		rsp_s r;
		int n;
		chk(32'(a_enabled), 32'h1);
		chk(32'(b_enabled), 32'h1);
		acc(1'b1, 32'h0, r, n);
		chk(32'(r.valid), 32'h0);
		chk(32'(fetch_allowed), 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_preload();
		rsp_s r;
		int n;
		logic [31:0] d;
		pm.xfer(1'b1, 32'h0, 32'hA5A5_0001, d);
		pm.xfer(1'b1, 32'h0080_0000, 32'h5A5A_0002, d);
		pm.xfer(1'b0, 32'h0, 32'h0, d);
		chk(d, 32'hA5A5_0001);
		pm.release_hold();
		repeat (8) @(negedge core_clk);
		chk(32'(fetch_allowed), 32'h1);
		acc(1'b1, 32'h0, r, n);
		chk(r.rdata, 32'hA5A5_0001);
		chk(32'(ext_fetch_req), 32'h0);
		chk(32'(n), 32'h3);
		acc(1'b0, 32'h0080_0000, r, n);
		chk(r.rdata, 32'h5A5A_0002);
		@(posedge core_clk);
		a_wait_cfg <= 3'h2;
		acc(1'b0, 32'h0, r, n);
		chk(32'(n), 32'h5);
		a_wait_cfg <= 3'h0;
		$display("test preload done");
	endtask : t_preload
	task automatic t_attr();
		rsp_s r;
		int n;
		for (int i = 1; i < 3; i++) begin
			@(posedge core_clk);
			data_attr <= '{mem_type_e'(i), 1'b0};
			fetch_attr <= '{mem_type_e'(i), 1'b0};
			acc(1'b0, 32'h4, r, n);
			chk(32'(r.fault), 32'h1);
			acc(1'b1, 32'h0, r, n);
			chk(32'(r.fault), 32'h1);
		end
		data_attr <= '{MEM_NORMAL, 1'b0};
		fetch_attr <= '{MEM_NORMAL, 1'b0};
		@(posedge core_clk);
		data_req <= '{1'b1, 1'b0, 32'hF000_0000, 32'h0};
		repeat (2) @(negedge core_clk);
		chk(32'(ext_data_req), 32'h1);
		@(posedge core_clk);
		data_req.valid <= 1'b0;
		repeat (2) @(posedge core_clk);
		$display("test attributes done");
	endtask : t_attr
	task automatic t_arb();
		int n;
		@(posedge core_clk);
		data_req <= '{1'b1, 1'b0, 32'h4, 32'h0};
		fetch_req <= '{1'b1, 1'b0, 32'h0, 32'h0};
		repeat (3) @(negedge core_clk);
		chk(32'(data_rsp.valid), 32'h1);
		chk(32'(fetch_rsp.valid), 32'h0);
		@(posedge core_clk);
		data_req.valid <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (!fetch_rsp.valid && n < 20);
		chk(fetch_rsp.rdata, 32'hA5A5_0001);
		@(posedge core_clk);
		fetch_req.valid <= 1'b0;
		repeat (2) @(posedge core_clk);
		$display("test arbitration done");
	endtask : t_arb
	initial begin
		// Reset spans six edges so the straps clear their synchronisers.
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		t_reset();
		t_preload();
		t_attr();
		t_arb();
		report_and_stop();
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		failures++;
		report_and_stop();
	end
endmodule : tightly_coupled_memory_port_tb
